// [rtl/bus_status_register_slave_rx.sv]
// Two-wire bus slave receiver with its software register file.
// Assumes bus pins arrive asynchronously and are resolved open-drain by
// the surroundings; register port and sleep/arbitration inputs are local.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Upper seven own-address bits are the slave address matched on the bus.
// R2 - Own-address LSB set enables answering general call address zero.
// R3 - Software enables interface and acknowledge, writing start, stop, flags zero.
// R4 - Own or general call address acknowledged only while acknowledge enable set.
// R5 - Wait for address; write direction receives, read direction is left alone.
// R6 - Own address with write bit sets the service flag with valid status.
// R7 - Addressed after lost arbitration reports 0x68 or 0x78.
// R8 - Acknowledge enable cleared mid-transfer gives not-acknowledge after next byte.
// R9 - With acknowledge enable zero, bus is watched but no address acknowledged.
// R10 - In clock-stopping sleep, address recognition still works when enabled.
// R11 - Sleep address match wakes the part, bus clock held until flag cleared.
// R12 - Data register need not hold the byte seen during sleep.
// R13 - Own write address acknowledged reports 0x60.
// R14 - Lost arbitration then own write address acknowledged reports 0x68.
// R15 - General call acknowledged reports 0x70.
// R16 - Lost arbitration then general call acknowledged reports 0x78.
// R17 - Own-address data byte acknowledged reports 0x80, byte in data register.
// R18 - Clearing the flag resumes; next byte acked per acknowledge enable.
// R19 - Own-address data byte not acknowledged reports 0x88.
// R20 - From 0x88, clearing the flag returns to unaddressed listening.
// R21 - Status codes assume prescaler bits read as zero.
// R22 - Bus clock held low while service flag set during a transfer.
module bus_status_register_slave_rx
  import bus_status_register_pkg::*;
(
  input wire logic core_clk, // System clock, 200 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [bus_status_register_pkg::ADDR_W-1:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic scl_in, // Bus clock pin level
  output logic scl_out, // Bus clock drive value, always low
  output logic scl_oe, // Bus clock pull-low enable
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Bus data drive value, always low
  output logic sda_oe, // Bus data pull-low enable
  input wire logic deep_sleep, // Clock-stopping sleep active
  input wire logic arb_lost, // Pulse from master side: arbitration lost
  output logic wake_req, // Wake the part after sleep address match
  output logic service_flag // Service flag level for interrupt logic
);
  import bus_status_register_pkg::*;

  bus_status_register_state_t state_reg, state_next;
  logic [7:0] control_reg;
  logic [7:0] own_addr_reg;
  logic [7:0] data_reg;
  logic [7:0] status_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic gc_sel_reg;
  logic lost_reg;
  logic flag_next;
  logic flag_set;
  logic [7:0] status_set;
  logic cnt_clr;
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;

  // Two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det = scl_sync && scl_prev && !sda_prev && sda_sync;

  logic if_en, ack_en;
  assign if_en = control_reg[CTL_IF_EN];
  assign ack_en = control_reg[CTL_ACK_EN];

  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own);
    addr_hit = (rx[7:1] == own[7:1]) || ((rx[7:1] == GENERAL_CALL_ADDR) && own[OWN_GC_EN]);
  endfunction

  function automatic logic [7:0] addr_code(input logic gc, input logic lost);
    if (gc) begin
      addr_code = lost ? ST_LOST_GC : ST_GC_ACK;
    end else begin
      addr_code = lost ? ST_LOST_OWN_W : ST_OWN_W_ACK;
    end
  endfunction

  logic rx_gc;
  assign rx_gc = (shift_reg[7:1] == GENERAL_CALL_ADDR);

  always_comb begin
    state_next = state_reg;
    flag_set = 1'b0;
    status_set = status_reg;
    cnt_clr = 1'b0;
    unique case (state_reg)
      S_IDLE, S_IGNORE: begin
        if (start_det) begin
          state_next = S_ADDR;
          cnt_clr = 1'b1;
        end
      end
      S_ADDR: begin
        if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
          // Read direction belongs to the transmitter side, not handled here
          if (ack_en && !shift_reg[0] && addr_hit(shift_reg, own_addr_reg)) begin // R1 R2 R4 R5 R9 R10
            state_next = S_ADDR_ACK;
          end else begin
            state_next = S_IGNORE;
          end
        end
      end
      S_ADDR_ACK: begin
        if (scl_fall) begin
          flag_set = 1'b1; // R6
          status_set = addr_code(gc_sel_reg, lost_reg); // R7 R13 R14 R15 R16
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!control_reg[CTL_SERVICE_FLAG]) begin
          state_next = S_DATA; // R18
          cnt_clr = 1'b1;
        end
      end
      S_DATA: begin
        if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
          state_next = ack_en ? S_DATA_ACK : S_DATA_NACK; // R8 R18
        end
      end
      S_DATA_ACK: begin
        if (scl_fall) begin
          flag_set = 1'b1;
          status_set = gc_sel_reg ? ST_GC_DATA_ACK : ST_OWN_DATA_ACK; // R17
          state_next = S_HOLD;
        end
      end
      S_DATA_NACK: begin
        if (scl_fall) begin
          flag_set = 1'b1;
          status_set = gc_sel_reg ? ST_GC_DATA_NACK : ST_OWN_DATA_NACK; // R19
          state_next = S_LAST;
        end
      end
      S_LAST: begin
        if (!control_reg[CTL_SERVICE_FLAG]) begin
          state_next = S_IDLE; // R20
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // Stop or repeated start in S_DATA or S_HOLD ends the transfer with the stop status
    if ((start_det || stop_det) && (state_reg == S_DATA || state_reg == S_HOLD)) begin
      flag_set = 1'b1;
      status_set = ST_STOP_RX;
      state_next = start_det ? S_ADDR : S_IDLE;
      cnt_clr = 1'b1;
    end else if (stop_det && state_reg != S_LAST) begin
      state_next = S_IDLE;
    end
    if (!if_en) begin
      state_next = S_IDLE;
      flag_set = 1'b0;
      status_set = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Byte assembly on rising bus clock
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (cnt_clr) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && (state_reg == S_ADDR || state_reg == S_DATA)
                 && bit_cnt_reg != BITS_PER_BYTE) begin
      shift_reg <= {shift_reg[6:0], sda_sync};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gc_sel_reg <= 1'b0;
    end else if (state_reg == S_ADDR && state_next == S_ADDR_ACK) begin
      gc_sel_reg <= rx_gc && own_addr_reg[OWN_GC_EN];
    end
  end

  // Arbitration-lost memory lasts until the address answer is reported or the address is ignored
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lost_reg <= 1'b0;
    end else if (arb_lost) begin
      lost_reg <= 1'b1;
    end else if (state_reg == S_ADDR_ACK && flag_set) begin
      lost_reg <= 1'b0;
    end else if (state_reg == S_IGNORE) begin
      lost_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_reg <= ST_IDLE;
    end else begin
      status_reg <= status_set;
    end
  end

  // Set wins over a software clear in the same cycle
  always_comb begin
    flag_next = control_reg[CTL_SERVICE_FLAG];
    if (reg_wr && reg_addr == OFF_CONTROL && reg_wdata[CTL_SERVICE_FLAG]) begin
      flag_next = 1'b0;
    end
    if (flag_set) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      control_reg <= RST_CONTROL;
    end else begin
      if (reg_wr && reg_addr == OFF_CONTROL) begin
        control_reg[CTL_ACK_EN] <= reg_wdata[CTL_ACK_EN]; // R3
        control_reg[CTL_START_REQ] <= reg_wdata[CTL_START_REQ];
        control_reg[CTL_STOP_REQ] <= reg_wdata[CTL_STOP_REQ];
        control_reg[CTL_IF_EN] <= reg_wdata[CTL_IF_EN];
        control_reg[CTL_IRQ_EN] <= reg_wdata[CTL_IRQ_EN];
        if (reg_wdata[CTL_WRITE_COLL] == 1'b0) begin
          control_reg[CTL_WRITE_COLL] <= 1'b0;
        end
      end
      // Data write while the service flag is clear is a collision
      if (reg_wr && reg_addr == OFF_DATA && !control_reg[CTL_SERVICE_FLAG]) begin
        control_reg[CTL_WRITE_COLL] <= 1'b1;
      end
      control_reg[CTL_SERVICE_FLAG] <= flag_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      own_addr_reg <= RST_OWN_ADDR;
    end else if (reg_wr && reg_addr == OFF_OWN_ADDR) begin
      own_addr_reg <= reg_wdata;
    end
  end

  // Bytes seen during sleep are not kept; software must not rely on them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_reg <= RST_DATA;
    end else if (state_reg == S_DATA && state_next != S_DATA && !deep_sleep
                 && bit_cnt_reg == BITS_PER_BYTE) begin
      data_reg <= shift_reg; // R12 R17
    end else if (reg_wr && reg_addr == OFF_DATA && control_reg[CTL_SERVICE_FLAG]) begin
      data_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wake_req <= 1'b0;
    end else if (state_reg == S_ADDR_ACK && deep_sleep) begin
      wake_req <= 1'b1; // R11
    end else if (!flag_next) begin
      wake_req <= 1'b0;
    end
  end

  // Pin drives registered from the next state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= (state_next == S_HOLD || state_next == S_LAST) && flag_next; // R11 R22
      sda_oe <= (state_next == S_ADDR_ACK || state_next == S_DATA_ACK);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign service_flag = control_reg[CTL_SERVICE_FLAG];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_CONTROL: reg_rdata <= control_reg;
        OFF_STATUS: reg_rdata <= {status_reg[7:3], 3'b000}; // R21
        OFF_DATA: reg_rdata <= data_reg;
        OFF_OWN_ADDR: reg_rdata <= own_addr_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  sequence addr_done_s;
    state_reg == S_ADDR && scl_fall && bit_cnt_reg == BITS_PER_BYTE && if_en;
  endsequence
  sequence ack_bit_end_s;
    state_reg == S_ADDR_ACK && scl_fall && if_en && !(start_det || stop_det);
  endsequence

  addr_refused_a: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    addr_done_s ##0 !ack_en |=> state_reg == S_IGNORE)
    else $error("address acknowledged with acknowledge disabled");
  addr_match_a: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    addr_done_s ##0 (ack_en && !shift_reg[0] && shift_reg[7:1] == own_addr_reg[7:1])
    |=> state_reg == S_ADDR_ACK ##1 sda_oe)
    else $error("own address not acknowledged");
  gc_ignore_a: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    addr_done_s ##0 (shift_reg[7:1] == GENERAL_CALL_ADDR && !own_addr_reg[OWN_GC_EN]
    && own_addr_reg[7:1] != GENERAL_CALL_ADDR) |=> state_reg == S_IGNORE)
    else $error("general call answered while disabled");
  read_dir_a: assert property (@(posedge core_clk) disable iff (!nrst) // R5
    addr_done_s ##0 shift_reg[0] |=> state_reg != S_ADDR_ACK)
    else $error("read direction entered receiver");
  addr_status_a: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    ack_bit_end_s |=> service_flag && (status_reg == ST_OWN_W_ACK
    || status_reg == ST_LOST_OWN_W || status_reg == ST_GC_ACK || status_reg == ST_LOST_GC))
    else $error("address phase ended without flag and status");
  own_code_a: assert property (@(posedge core_clk) disable iff (!nrst) // R13
    ack_bit_end_s ##0 (!gc_sel_reg && !lost_reg) |=> status_reg == ST_OWN_W_ACK)
    else $error("own address status not 0x60");
  data_nack_a: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    state_reg == S_DATA && scl_fall && bit_cnt_reg == BITS_PER_BYTE && !ack_en && if_en
    && !stop_det && !start_det |=> state_reg == S_DATA_NACK && !sda_oe)
    else $error("byte acknowledged after acknowledge disabled");
  stretch_a: assert property (@(posedge core_clk) disable iff (!nrst) // R22
    (state_reg == S_HOLD && service_flag) ##1 (state_reg == S_HOLD && service_flag)
    |-> scl_oe)
    else $error("bus clock not held while flag set");
  release_a: assert property (@(posedge core_clk) disable iff (!nrst) // R20
    state_reg == S_LAST && !service_flag && if_en |=> state_reg == S_IDLE ##1 !scl_oe)
    else $error("not-acknowledge state not left after flag clear");
  flag_win_a: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    flag_set |=> service_flag)
    else $error("flag set lost against clear");
endmodule

`default_nettype wire

// [rtl/bus_status_register_pkg.sv]
// Constants shared by the two-wire slave receiver: register map, field
// positions, reset values and bus status codes.
// Assumes an 8-bit register port with three address bits.
package bus_status_register_pkg;
  localparam int ADDR_W = 3;
  // Register offsets (word index on the register port)
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_STATUS = 3'h1;
  localparam logic [2:0] OFF_DATA = 3'h2;
  localparam logic [2:0] OFF_OWN_ADDR = 3'h3;
  // Control register fields
  localparam int CTL_SERVICE_FLAG = 7;
  localparam int CTL_ACK_EN = 6;
  localparam int CTL_START_REQ = 5;
  localparam int CTL_STOP_REQ = 4;
  localparam int CTL_WRITE_COLL = 3;
  localparam int CTL_IF_EN = 2;
  localparam int CTL_IRQ_EN = 0;
  // Own address register: address in [7:1], general call enable in [0]
  localparam int OWN_GC_EN = 0;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_OWN_ADDR = 8'hFE;
  localparam logic [7:0] RST_DATA = 8'hFF;
  // Status codes, prescaler bits always read as zero
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_OWN_W_ACK = 8'h60;
  localparam logic [7:0] ST_LOST_OWN_W = 8'h68;
  localparam logic [7:0] ST_GC_ACK = 8'h70;
  localparam logic [7:0] ST_LOST_GC = 8'h78;
  localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_RX = 8'hA0;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_ADDR_ACK = 4'b0010,
    S_HOLD = 4'b0011,
    S_DATA = 4'b0100,
    S_DATA_ACK = 4'b0101,
    S_DATA_NACK = 4'b0110,
    S_LAST = 4'b0111,
    S_IGNORE = 4'b1000
  } bus_status_register_state_t;
endpackage

// [sim/bus_status_register_bus_master.sv]
// Behavioural two-wire bus master that writes bytes to the slave.
// Assumes the bench resolves both wires open-drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module bus_status_register_bus_master (
  input wire logic scl, // Resolved bus clock
  input wire logic sda, // Resolved bus data
  output logic scl_low, // Pull bus clock low
  output logic sda_low // Pull bus data low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Slave may stretch; give up after 20 us and let the bench judge
  task automatic wait_high();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 20000) begin
      #1 n++;
    end
  endtask
  // One clock pulse with 48 ns period, data sampled mid high phase
  task automatic pulse(output logic seen);
    wait_high();
    #12 seen = sda;
    #12 scl_low = 1'b1;
  endtask
  task automatic start_cond();
    #24 sda_low = 1'b1;
    #24 scl_low = 1'b1;
  endtask
  // Most significant bit first, then the answer bit released to the slave
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = ~b[i];
      #12 pulse(s);
    end
    #12 sda_low = 1'b0;
    #12 pulse(s);
    ack = ~s;
  endtask
  task automatic stop_cond();
    #12 sda_low = 1'b1;
    #12 wait_high();
    #24 sda_low = 1'b0;
    #48;
  endtask
endmodule
`default_nettype wire

// [sim/two_wire_slave_receiver_tb.sv]
// Self-checking bench for the two-wire slave receiver.
// Assumes the bus master model drives the far side of both wires.
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_receiver_tb;
  import bus_status_register_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, deep_sleep, arb_lost, ack;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic scl_out, scl_oe, sda_out, sda_oe, wake_req, service_flag, m_scl_low, m_sda_low;
  logic [7:0] rst_tab [5] = '{RST_CONTROL, ST_IDLE, RST_DATA, RST_OWN_ADDR, 8'h00};
  wire scl_w;
  wire sda_w;
  int failures, checks;
  assign scl_w = ~(m_scl_low | (scl_oe & ~scl_out));
  assign sda_w = ~(m_sda_low | (sda_oe & ~sda_out));
  bus_status_register_slave_rx DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .deep_sleep(deep_sleep), .arb_lost(arb_lost),
    .wake_req(wake_req), .service_flag(service_flag));
  bus_status_register_bus_master master (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bit_check(input string name, input logic seen, input logic exp);
    check(name, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic expect_status(input logic [7:0] exp);
    reg_read(OFF_STATUS, rd);
    check("status", rd, exp);
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    master.send_byte(b, ack);
    bit_check("ack", ack, exp_ack);
    // Ninth falling edge needs the synchroniser delay before status moves
    settle();
  endtask
  task automatic address(input logic [7:0] b, input logic exp_ack);
    master.start_cond();
    send(b, exp_ack);
  endtask
  // Refused address: no answer, no flag, bus left free
  task automatic refused(input logic [7:0] b);
    address(b, 1'b0);
    master.stop_cond();
    bit_check("flag", service_flag, 1'b0);
  endtask
  // Stop while addressed raises the flag again, so clear it twice
  task automatic close_out();
    reg_write(OFF_CONTROL, 8'hC4);
    master.stop_cond();
    reg_write(OFF_CONTROL, 8'hC4);
  endtask
  task automatic pulse_arb();
    @(posedge core_clk);
    arb_lost <= 1'b1;
    @(posedge core_clk);
    arb_lost <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run needs about 7 us of bus time
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    deep_sleep = 1'b0;
    arb_lost = 1'b0;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_read(3'(i), rd);
      check("reset value", rd, rst_tab[i]);
    end
    reg_write(OFF_OWN_ADDR, 8'h55);
    reg_read(OFF_OWN_ADDR, rd);
    check("own address", rd, 8'h55);
    reg_write(OFF_CONTROL, 8'h44);
    address(8'h54, 1'b1);
    expect_status(ST_OWN_W_ACK);
    bit_check("flag", service_flag, 1'b1);
    bit_check("stretch", scl_oe, 1'b1);
    reg_write(OFF_CONTROL, 8'hC4);
    settle();
    bit_check("stretch", scl_oe, 1'b0);
    send(8'hA5, 1'b1);
    expect_status(ST_OWN_DATA_ACK);
    reg_read(OFF_DATA, rd);
    check("data", rd, 8'hA5);
    reg_write(OFF_CONTROL, 8'h84);
    send(8'h3C, 1'b0);
    expect_status(ST_OWN_DATA_NACK);
    reg_write(OFF_CONTROL, 8'hC4);
    master.stop_cond();
    bit_check("flag", service_flag, 1'b0);
    address(8'h00, 1'b1);
    expect_status(ST_GC_ACK);
    reg_write(OFF_CONTROL, 8'hC4);
    master.stop_cond();
    expect_status(ST_STOP_RX);
    reg_write(OFF_CONTROL, 8'hC4);
    refused(8'h56);
    refused(8'h55);
    reg_write(OFF_CONTROL, 8'h04);
    refused(8'h54);
    reg_write(OFF_CONTROL, 8'h44);
    reg_write(OFF_OWN_ADDR, 8'h54);
    refused(8'h00);
    pulse_arb();
    address(8'h54, 1'b1);
    expect_status(ST_LOST_OWN_W);
    close_out();
    reg_write(OFF_OWN_ADDR, 8'h55);
    pulse_arb();
    address(8'h00, 1'b1);
    expect_status(ST_LOST_GC);
    close_out();
    @(posedge core_clk);
    deep_sleep <= 1'b1;
    address(8'h54, 1'b1);
    settle();
    bit_check("wake", wake_req, 1'b1);
    bit_check("stretch", scl_oe, 1'b1);
    reg_write(OFF_CONTROL, 8'hC4);
    settle();
    bit_check("wake", wake_req, 1'b0);
    bit_check("stretch", scl_oe, 1'b0);
    send(8'h81, 1'b1);
    expect_status(ST_OWN_DATA_ACK);
    // Byte taken while asleep is not kept; last kept byte was the not-acknowledged 0x3C
    reg_read(OFF_DATA, rd);
    check("sleep data", rd, 8'h3C);
    @(posedge core_clk);
    deep_sleep <= 1'b0;
    reg_write(OFF_CONTROL, 8'hC4);
    send(8'h7E, 1'b1);
    expect_status(ST_OWN_DATA_ACK);
    reg_read(OFF_DATA, rd);
    check("data", rd, 8'h7E);
    close_out();
    test_done();
  end
endmodule
`default_nettype wire
